// ===== lvmc_top.sv
// Supply monitor control with an AXI4-Lite register slave.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lvmc_regs.svh"
module lvmc_top
    import lvmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        cmp_below_fall,
    input  wire logic        cmp_above_rise,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic             monitor_enable,
    output logic             warn_level_sel,
    output logic             reset_request,
    output logic             irq
);
    lvmc_cfg_t   cfg_r;
    logic        cfg_written_r;
    logic        flag_r;
    lvmc_state_t state_r;
    lvmc_state_t state_nxt;
    logic [1:0]  ist_r;
    logic [1:0]  imask_r;
    logic [1:0]  cmp_raw;
    logic [1:0]  cmp_sync;
    lvmc_cmp_t   cmp;
    logic        aw_held_r;
    logic [7:0]  aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        rd_pend_r;

    assign cmp_raw = {cmp_below_fall, cmp_above_rise};

    lvmc_sync #(
        .WIDTH   (2)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .async_in(cmp_raw),
        .sync_out(cmp_sync)
    );

    assign cmp = lvmc_cmp_t'(cmp_sync);

    // Monitor activity: powered, and in stop only when kept on.
    wire mon_active = !cfg_r.pwr_off && (!stop_mode || cfg_r.stop_keep);
    wire rst_enable = mon_active && !cfg_r.rst_dis;
    assign monitor_enable = mon_active;
    assign warn_level_sel = cfg_r.trip_sel;
    // The analog side follows warn_level_sel. Raising the level while the
    // supply sits between the new thresholds shows no below_fall, so the
    // rising output is checked once the synchroniser has caught up.
    logic [2:0] lvl_wait_r;
    wire lvl_check    = (lvl_wait_r == 3'h1);
    wire rise_seen    = cmp.above_rise;
    wire raised_low   = lvl_check && cfg_r.trip_sel && !rise_seen;
    wire trip_now     = rst_enable && (cmp.below_fall || raised_low);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LVMC_OK: begin
                if (trip_now) begin
                    state_nxt = LVMC_RESET_HOLD;
                end
            end
            LVMC_RESET_HOLD: begin
                if (rise_seen) begin
                    state_nxt = LVMC_OK;
                end
            end
            default: state_nxt = LVMC_OK;
        endcase
    end

    // The hold ignores configuration changes so a trip is never cut short.
    assign reset_request = (state_r == LVMC_RESET_HOLD);

    // Write channel handshake: address and data taken in either order.
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    wire [7:0]  wa    = aw_fire ? s_axi_awaddr : aw_addr_r;
    wire [31:0] wd    = w_fire ? s_axi_wdata : w_data_r;
    wire [3:0]  ws    = w_fire ? s_axi_wstrb : w_strb_r;
    wire wr_do  = (aw_fire || aw_held_r) && (w_fire || w_held_r);
    wire wr_cfg = wr_do && ws[0] && (wa == `LVMC_OFS_CONFIG);
    wire wr_ist = wr_do && ws[0] && (wa == `LVMC_OFS_IRQ_STAT);
    wire wr_msk = wr_do && ws[0] && (wa == `LVMC_OFS_IRQ_MASK);
    wire wr_ok  = wr_cfg || wr_ist || wr_msk || (wa == `LVMC_OFS_STATUS);
    wire new_trip_sel = wd[`LVMC_BIT_TRIP_SEL];
    wire lvl_raise    = wr_cfg && new_trip_sel && !cfg_r.trip_sel;

    // Counts the synchroniser latency after the level is raised, so the
    // check sees the comparator already switched to the new level.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lvl_wait_r <= 3'h0;
        end else if (lvl_raise) begin
            lvl_wait_r <= `LVMC_LVL_SETTLE;
        end else if (lvl_wait_r != 3'h0) begin
            lvl_wait_r <= lvl_wait_r - 3'h1;
        end
    end

    // Only the reset disable and trip level bits may be rewritten later.
    lvmc_cfg_t cfg_nxt;
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_cfg) begin
            cfg_nxt.rst_dis  = wd[`LVMC_BIT_RST_DIS];
            cfg_nxt.trip_sel = wd[`LVMC_BIT_TRIP_SEL];
            if (!cfg_written_r) begin
                cfg_nxt.pwr_off   = wd[`LVMC_BIT_PWR_OFF];
                cfg_nxt.stop_keep = wd[`LVMC_BIT_STOP_KEEP];
            end
        end
    end

    // Events: supply went low, supply recovered. Set wins over clear.
    wire ev_low  = mon_active && cmp.below_fall && !flag_r;
    wire ev_high = mon_active && rise_seen && flag_r;
    wire [1:0] ev = {ev_high, ev_low};
    wire [1:0] ist_nxt = (ist_r & ~(wr_ist ? wd[1:0] : 2'h0)) | ev;
    // Masked event status only; the monitor's own request never feeds irq.
    assign irq = |(ist_r & imask_r);

    wire flag_nxt = !mon_active ? flag_r :
                    cmp.below_fall ? 1'b1 :
                    rise_seen ? 1'b0 : flag_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r       <= LVMC_OK;
            cfg_r         <= lvmc_cfg_t'(`LVMC_CONFIG_RESET);
            cfg_written_r <= 1'b0;
            flag_r        <= 1'b0;
            ist_r         <= 2'h0;
            imask_r       <= `LVMC_MASK_RESET;
        end else begin
            state_r       <= state_nxt;
            cfg_r         <= cfg_nxt;
            cfg_written_r <= cfg_written_r || wr_cfg;
            flag_r        <= flag_nxt;
            ist_r         <= ist_nxt;
            imask_r       <= wr_msk ? wd[1:0] : imask_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (aw_fire) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= wr_do ? 1'b0 : (aw_held_r || aw_fire);
            w_held_r  <= wr_do ? 1'b0 : (w_held_r || w_fire);
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read path: one read at a time, data registered.
    assign s_axi_arready = !rd_pend_r;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [31:0] rd_cfg  = {28'h0, cfg_r.rst_dis, cfg_r.trip_sel,
                           cfg_r.pwr_off, cfg_r.stop_keep};
    wire [31:0] rd_stat = {30'h0, reset_request, flag_r};
    wire [31:0] rd_ist  = {30'h0, ist_r};
    wire [31:0] rd_msk  = {30'h0, imask_r};
    wire rd_hit = (s_axi_araddr == `LVMC_OFS_CONFIG) ||
                  (s_axi_araddr == `LVMC_OFS_STATUS) ||
                  (s_axi_araddr == `LVMC_OFS_IRQ_STAT) ||
                  (s_axi_araddr == `LVMC_OFS_IRQ_MASK);
    wire [31:0] rd_mux =
        (s_axi_araddr == `LVMC_OFS_CONFIG)   ? rd_cfg  :
        (s_axi_araddr == `LVMC_OFS_STATUS)   ? rd_stat :
        (s_axi_araddr == `LVMC_OFS_IRQ_STAT) ? rd_ist  :
        (s_axi_araddr == `LVMC_OFS_IRQ_MASK) ? rd_msk  : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_pend_r    <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (ar_fire) begin
            rd_pend_r    <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            rd_pend_r    <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end
    end

    a_trip_enters_hold: assert property (@(posedge clk)
        disable iff (sys_rst)
        (state_r == LVMC_OK && trip_now) |=> reset_request)
        else $error("trip did not raise reset request");
    a_hold_until_rise: assert property (@(posedge clk)
        disable iff (sys_rst)
        (reset_request && !rise_seen) |=> reset_request)
        else $error("reset released before supply rose");
    a_hold_release: assert property (@(posedge clk)
        disable iff (sys_rst)
        (reset_request && rise_seen) |=> !reset_request)
        else $error("reset not released after rise");
    a_no_trip_off: assert property (@(posedge clk)
        disable iff (sys_rst)
        (!reset_request && (cfg_r.pwr_off || cfg_r.rst_dis)) |=>
        !reset_request)
        else $error("disabled monitor raised reset");
    a_stop_gate: assert property (@(posedge clk)
        disable iff (sys_rst)
        (stop_mode && !cfg_r.stop_keep) |-> !monitor_enable)
        else $error("monitor active in stop without keep-on");
    a_flag_sets: assert property (@(posedge clk)
        disable iff (sys_rst)
        (mon_active && cmp.below_fall) |=> flag_r)
        else $error("flag not set on low supply");
    a_flag_holds: assert property (@(posedge clk)
        disable iff (sys_rst)
        (!cmp.below_fall && !rise_seen) |=> $stable(flag_r))
        else $error("flag changed between thresholds");
    a_flag_reset: assert property (@(posedge clk)
        sys_rst |=> !flag_r && !cfg_r.trip_sel)
        else $error("reset left flag or level set");
    a_trip_rewrite: assert property (@(posedge clk)
        disable iff (sys_rst)
        wr_cfg |=> cfg_r.trip_sel == $past(new_trip_sel))
        else $error("trip level write lost");
    a_wait_active: assert property (@(posedge clk)
        disable iff (sys_rst)
        (wait_mode && !stop_mode && !cfg_r.pwr_off) |-> monitor_enable)
        else $error("monitor idle in wait");
    a_raise_trips: assert property (@(posedge clk)
        disable iff (sys_rst)
        (raised_low && rst_enable && !reset_request) |=> reset_request)
        else $error("raised level below its rising point did not trip");
    a_cfg_write_once: assert property (@(posedge clk)
        disable iff (sys_rst)
        (wr_cfg && cfg_written_r) |=>
        ($stable(cfg_r.pwr_off) && $stable(cfg_r.stop_keep)))
        else $error("write-once configuration bit changed");
    a_on_from_reset: assert property (@(posedge clk)
        sys_rst |=> (!cfg_r.pwr_off && !cfg_r.rst_dis))
        else $error("monitor not powered out of reset");
endmodule

// ===== lvmc_regs.svh
// Register offsets, field positions and reset values of the supply monitor.
`ifndef LVMC_REGS_SVH
`define LVMC_REGS_SVH
`define LVMC_OFS_CONFIG    8'h00
`define LVMC_OFS_STATUS    8'h04
`define LVMC_OFS_IRQ_STAT  8'h08
`define LVMC_OFS_IRQ_MASK  8'h0C
`define LVMC_BIT_STOP_KEEP 0
`define LVMC_BIT_PWR_OFF   1
`define LVMC_BIT_TRIP_SEL  2
`define LVMC_BIT_RST_DIS   3
`define LVMC_BIT_FLAG      0
`define LVMC_BIT_RST_REQ   1
`define LVMC_BIT_EV_LOW    0
`define LVMC_BIT_EV_HIGH   1
`define LVMC_CONFIG_RESET  4'h0
`define LVMC_MASK_RESET    2'h0
`define LVMC_SYNC_STAGES   3
`define LVMC_LVL_SETTLE    3'h5
`endif

// ===== lvmc_pkg.sv
// Types shared by the supply monitor files.
package lvmc_pkg;
    typedef struct packed {
        logic rst_dis;
        logic trip_sel;
        logic pwr_off;
        logic stop_keep;
    } lvmc_cfg_t;
    typedef struct packed {
        logic below_fall;
        logic above_rise;
    } lvmc_cmp_t;
    typedef enum logic [1:0] {
        LVMC_OK,
        LVMC_RESET_HOLD
    } lvmc_state_t;
endpackage

// ===== lvmc_sync.sv
// Three-stage synchroniser with agreement filter for comparator inputs.
`timescale 1ns/1ps
`include "lvmc_regs.svh"
module lvmc_sync
    import lvmc_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // The first stage feeds only the second; the filter looks at 2 and 3.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_r[g]     <= 1'b0;
                    s2_r[g]     <= 1'b0;
                    s3_r[g]     <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    s1_r[g] <= async_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        sync_out[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate
endmodule

// ===== lvmc_cmp_model.sv
// Behavioural model of the analog supply comparator at the far side.
`timescale 1ns/1ps
module lvmc_cmp_model #(
    parameter int FALL_LO = 2400,
    parameter int RISE_LO = 2500,
    parameter int FALL_HI = 2800,
    parameter int RISE_HI = 2900
) (
    input  wire logic   enable,
    input  wire logic   warn_sel,
    input  wire integer vdd_mv,
    output logic        below_fall,
    output logic        above_rise
);
    int fall_mv;
    int rise_mv;
    // Thresholds are arbitrary millivolt figures; only their order matters.
    assign fall_mv = warn_sel ? FALL_HI : FALL_LO;
    assign rise_mv = warn_sel ? RISE_HI : RISE_LO;
    // An unpowered comparator pulls both outputs low, not the last value.
    assign below_fall = enable && (vdd_mv < fall_mv);
    assign above_rise = enable && (vdd_mv > rise_mv);
endmodule

// ===== lvmc_top_test.sv
// Register-level testbench for the supply monitor control block.
`timescale 1ns/1ps
`include "lvmc_regs.svh"
module lvmc_top_test;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0]  wst = 4'hF;
    logic        awr, wr, bv, arr, rv, m_en, warn, rst_req, irq, below, above;
    logic [1:0]  br, rr;
    logic [31:0] rd;
    logic        wait_m = 1'b0, stop_m = 1'b0;
    int          vdd = 3300;
    int          err_total = 0;
    int          compares = 0;

    always #2 clk = ~clk;

    lvmc_top uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(wst),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .cmp_below_fall(below), .cmp_above_rise(above),
        .wait_mode(wait_m), .stop_mode(stop_m), .monitor_enable(m_en),
        .warn_level_sel(warn), .reset_request(rst_req), .irq(irq));

    lvmc_cmp_model cmp (.enable(m_en), .warn_sel(warn), .vdd_mv(vdd),
        .below_fall(below), .above_rise(above));

    task tally_and_finish;
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // A handshake that never completes is scored as a mismatch.
    task hang;
        chk(32'h0, 32'h1);
        tally_and_finish();
    endtask

    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int   n;
        logic ad;
        logic wdn;
        n = 0;
        ad = 1'b0;
        wdn = 1'b0;
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        while (!(ad && wdn)) begin
            @(posedge clk);
            if (awr && !ad) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (wr && !wdn) begin
                wdn = 1'b1;
                wv <= 1'b0;
            end
            n++;
            if (n > 50) hang();
        end
        bre <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) hang();
        end while (!bv);
        chk(32'(br), 32'(e));
        bre <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) hang();
        end while (!arr);
        arv <= 1'b0;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 100) hang();
        end while (!rv);
        chk(rd, e);
        chk(32'(rr), 32'(er));
        rre <= 1'b0;
    endtask

    // Synchroniser plus flag update take at most five edges.
    task settle;
        repeat (8) @(posedge clk);
    endtask

    task rst8;
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    initial begin
        rst8();
        @(posedge clk);
        chk(32'(m_en), 32'h1);
        rdchk(`LVMC_OFS_CONFIG, 32'h0, 2'h0);
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        rdchk(8'h10, 32'h0, 2'h2);
        rdchk(`LVMC_OFS_IRQ_MASK, 32'h0, 2'h0);
        $display("test defaults done");
        axw(`LVMC_OFS_IRQ_MASK, 32'h3, 2'h0);
        vdd <= 2300;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h3, 2'h0);
        chk(32'(rst_req), 32'h1);
        chk(32'(irq), 32'h1);
        vdd <= 2450;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h3, 2'h0);
        vdd <= 2600;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        chk(32'(rst_req), 32'h0);
        rdchk(`LVMC_OFS_IRQ_STAT, 32'h3, 2'h0);
        axw(`LVMC_OFS_IRQ_STAT, 32'h1, 2'h0);
        rdchk(`LVMC_OFS_IRQ_STAT, 32'h2, 2'h0);
        axw(`LVMC_OFS_IRQ_STAT, 32'h2, 2'h0);
        chk(32'(irq), 32'h0);
        $display("test forced reset done");
        axw(`LVMC_OFS_IRQ_MASK, 32'h2, 2'h0);
        axw(`LVMC_OFS_CONFIG, 32'h8, 2'h0);
        vdd <= 2300;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h1, 2'h0);
        chk(32'(irq), 32'h0);
        vdd <= 2450;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h1, 2'h0);
        axw(`LVMC_OFS_CONFIG, 32'hA, 2'h0);
        rdchk(`LVMC_OFS_CONFIG, 32'h8, 2'h0);
        wst <= 4'h0;
        axw(`LVMC_OFS_CONFIG, 32'h0, 2'h2);
        wst <= 4'hF;
        rdchk(`LVMC_OFS_CONFIG, 32'h8, 2'h0);
        chk(32'(m_en), 32'h1);
        $display("test polled done");
        axw(`LVMC_OFS_CONFIG, 32'h4, 2'h0);
        chk(32'(warn), 32'h1);
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h3, 2'h0);
        vdd <= 2950;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        chk(32'(irq), 32'h1);
        axw(`LVMC_OFS_CONFIG, 32'h0, 2'h0);
        vdd <= 2850;
        settle();
        axw(`LVMC_OFS_CONFIG, 32'h4, 2'h0);
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h2, 2'h0);
        chk(32'(rst_req), 32'h1);
        vdd <= 2950;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        wait_m <= 1'b1;
        vdd <= 2700;
        settle();
        chk(32'(m_en), 32'h1);
        rdchk(`LVMC_OFS_STATUS, 32'h3, 2'h0);
        vdd <= 2950;
        settle();
        wait_m <= 1'b0;
        stop_m <= 1'b1;
        vdd <= 2300;
        settle();
        chk(32'(m_en), 32'h0);
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        $display("test warning level done");
        stop_m <= 1'b0;
        vdd <= 3300;
        rst8();
        @(posedge clk);
        chk(32'(warn), 32'h0);
        axw(`LVMC_OFS_CONFIG, 32'h1, 2'h0);
        stop_m <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk(32'(m_en), 32'h1);
        vdd <= 2300;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h3, 2'h0);
        stop_m <= 1'b0;
        vdd <= 2450;
        rst8();
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        $display("test stop mode done");
        axw(`LVMC_OFS_CONFIG, 32'h2, 2'h0);
        @(posedge clk);
        chk(32'(m_en), 32'h0);
        vdd <= 2300;
        settle();
        rdchk(`LVMC_OFS_STATUS, 32'h0, 2'h0);
        $display("test power off done");
        tally_and_finish();
    end
endmodule
